// [src/dhm_consts.vh]
// Constants for the drive health rate and thermal monitor.
`ifndef DHM_CONSTS_VH
`define DHM_CONSTS_VH
// APB register byte addresses.
`define DHM_ADDR_CTRL      12'h000
`define DHM_ADDR_INTERVAL  12'h004
`define DHM_ADDR_ERRTHR    12'h008
`define DHM_ADDR_PREDTHR   12'h00c
`define DHM_ADDR_REFTEMP   12'h010
`define DHM_ADDR_TEMP      12'h014
`define DHM_ADDR_STATUS    12'h018
`define DHM_ADDR_HIST      12'h01c
`define DHM_ADDR_SENSE     12'h020
`define DHM_ADDR_LOGPAGE   12'h024
// Control register field positions.
`define DHM_CTRL_DISABLE   0
`define DHM_CTRL_WARN_EN   1
`define DHM_CTRL_EXCEPTION_REPORT_METHOD_LO   4
`define DHM_CTRL_EXCEPTION_REPORT_METHOD_HI   7
// Status register field positions (write one to clear).
`define DHM_ST_FIXED_TRIP  0
`define DHM_ST_REF_TRIP    1
`define DHM_ST_ROUNDED     2
`define DHM_ST_FRAME_SAVE  3
`define DHM_ST_PRED_LO     8
// Reset values and limits.
`define DHM_TEMP_LIMIT     8'h44
`define DHM_RST_INTERVAL   16'h0400
`define DHM_RST_ERRTHR     16'h0010
`define DHM_RST_PREDTHR    8'h08
// Sense code words.
`define DHM_SENSE_TEMP     24'h010b01
`define DHM_SENSE_PRED     24'h015d00
`define DHM_SENSE_ROUND    24'h013700
// Temperature log page and parameter codes.
`define DHM_LOG_PAGE       8'h0d
`define DHM_PARAM_PRIMARY  16'h0000
`define DHM_PARAM_REF      16'h0001
// Sample period: ten minutes at 50 MHz.
`define DHM_SAMPLE_MIN     10
`define DHM_CLK_HZ         50000000
// Written out at 36 bits: the cycle count, 30000000000, overflows 32-bit math.
`define DHM_SAMPLE_CYC     36'd30000000000
`endif

// [src/dhm_monitor.v]
// Drive health monitor: per-attribute error rate judging and thermal trip logic.
`default_nettype none
`include "dhm_consts.vh"
module dhm_monitor #(
    parameter         NUM_ATTR   = 4,
    parameter         CNT_W      = 16,
    parameter         HIST_W     = 8,
    parameter [35:0]  SAMPLE_CYC = `DHM_SAMPLE_CYC
) (
    // Clock and reset.
    input  wire                ref_clk,
    input  wire                rst,
    // APB slave.
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output reg                 pready,
    output reg                 pslverr,
    // Attribute event strobes, same clock domain.
    input  wire [NUM_ATTR-1:0] opStrobe,
    input  wire [NUM_ATTR-1:0] errStrobe,
    // Temperature sensor, asynchronous level bus.
    input  wire [7:0]          sensorTemp,
    // Host-facing events.
    output reg                 predFailEvent,
    output reg                 tempWarnEvent,
    output reg  [23:0]         senseCode,
    output reg  [7:0]          senseFru,
    output reg  [3:0]          exceptionReportMethod,
    output reg                 frameSaveReq
);

    // Each attribute lane judges its error rate over a window.
    // A window ends on the operation that fills the interval,
    // or at once when the error tally passes its threshold.
    // The thermal side samples the sensor on a slow timer.
    // The bus answers every access after one wait state.
    // Every host-facing output is a flip-flop.
    // Limitation: a sensor value that never holds still is ignored.

    // Register map, byte addresses.
    // 0x00 control: disable, warning enable, method.
    // 0x04 interval length in operations.
    // 0x08 error threshold per window.
    // 0x0c predictive threshold for history.
    // 0x10 reference trip temperature.
    // 0x14 last measured temperature.
    // 0x18 sticky status, write one to clear.
    // 0x1c history of the selected attribute.
    // 0x20 sense word with the unit field.
    // 0x24 temperature log page view.

    // Status bits.
    // Bit 0 fixed trip, bit 1 reference trip.
    // Bit 2 reference clamped on write.
    // Bit 3 data frame saved.
    // Bits 8 and up: predictive flag per attribute.

    // Software-visible configuration.
    reg              healthMonitorDisable_q;
    reg              tempWarningEnable_q;
    reg  [3:0]       exceptionReportMethod_q;
    reg  [CNT_W-1:0] intervalLen_q;
    reg  [CNT_W-1:0] errThresh_q;
    reg  [HIST_W-1:0] predThresh_q;
    reg  [7:0]       refTemp_q;
    reg  [7:0]       measTemp_q;
    reg  [3:0]       status_q;
    reg  [NUM_ATTR-1:0] predSticky_q;
    reg  [15:0]      logParam_q;
    reg  [2:0]       attrSel_q;

    // Per-attribute state, one lane per attribute.
    reg  [CNT_W-1:0]  opCnt_q   [0:NUM_ATTR-1];
    reg  [CNT_W-1:0]  errCnt_q  [0:NUM_ATTR-1];
    reg  [HIST_W-1:0] hist_q    [0:NUM_ATTR-1];
    wire [NUM_ATTR-1:0] predHit;

    // APB handshake decode; every access finishes in its second access cycle, after one wait state.
    wire apbAcc = psel & penable;
    // A write lands where pready is taken, so it happens once.
    wire apbWr  = apbAcc & pwrite & pready;
    wire apbRd  = apbAcc & ~pwrite;

    // Lane notes: history saturates at both ends, and a
    // disabled monitor freezes every lane where it stands.
    // A window both full and bad in one cycle counts as bad.
    // Software keeps the error threshold below the interval.

    genvar g;
    generate
        for (g = 0; g < NUM_ATTR; g = g + 1) begin : gAttr
            wire windowEnd  = opStrobe[g] & (opCnt_q[g] + 1'b1 >= intervalLen_q);
            wire [CNT_W-1:0] errNextW = errCnt_q[g] + {{(CNT_W-1){1'b0}}, errStrobe[g]};
            wire badWin     = errNextW > errThresh_q;
            wire goodWin    = windowEnd & ~badWin;
            // Window judging runs only while monitoring is enabled; a bad tally ends the window early.
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    opCnt_q[g]  <= {CNT_W{1'b0}};
                    errCnt_q[g] <= {CNT_W{1'b0}};
                    hist_q[g]   <= {HIST_W{1'b0}};
                end else if (!healthMonitorDisable_q) begin
                    if (badWin | goodWin) begin
                        opCnt_q[g]  <= {CNT_W{1'b0}};
                        errCnt_q[g] <= {CNT_W{1'b0}};
                    end else begin
                        opCnt_q[g]  <= opCnt_q[g] + {{(CNT_W-1){1'b0}}, opStrobe[g]};
                        errCnt_q[g] <= errNextW;
                    end
                    // Saturate at the top as well so a long bad run cannot wrap to zero.
                    if (badWin && hist_q[g] != {HIST_W{1'b1}}) begin
                        hist_q[g] <= hist_q[g] + 1'b1;
                    end else if (goodWin && hist_q[g] != {HIST_W{1'b0}}) begin
                        hist_q[g] <= hist_q[g] - 1'b1;
                    end
                end
            end

            // The hit is a level; the sticky bit makes it one event.
            // A zero threshold switches predictive signalling off.
            assign predHit[g] = (hist_q[g] >= predThresh_q) & (predThresh_q != {HIST_W{1'b0}});
        end
    endgenerate

    // Sensor bits may settle at different edges; two equal
    // stages keep a torn value away from the comparators.
    // Stage one is read only by stage two.

    // Three-stage synchroniser on the sensor bus; a value counts once stages two and three agree.
    reg  [7:0] tSync1_q;
    reg  [7:0] tSync2_q;
    reg  [7:0] tSync3_q;
    reg  [7:0] tStable_q;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tSync1_q  <= 8'h00;
            tSync2_q  <= 8'h00;
            tSync3_q  <= 8'h00;
            tStable_q <= 8'h00;
        end else begin
            tSync1_q <= sensorTemp;
            tSync2_q <= tSync1_q;
            tSync3_q <= tSync2_q;
            if (tSync2_q == tSync3_q) begin
                tStable_q <= tSync3_q;
            end
        end
    end

    // The default period is ten minutes at 50 MHz; a bench
    // may shorten it through the parameter.
    // The power-up sample waits for the synchroniser to fill.

    // Sample timer: first sample shortly after reset release, then every period.
    reg  [35:0] sampTmr_q;
    reg         firstDone_q;
    reg  [2:0]  settle_q;
    reg         sampleNow_q;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sampTmr_q   <= 36'h0;
            firstDone_q <= 1'b0;
            settle_q    <= 3'h0;
            sampleNow_q <= 1'b0;
        end else begin
            sampleNow_q <= 1'b0;
            if (!firstDone_q) begin
                // Wait for the synchroniser to fill before the power-up sample.
                settle_q <= settle_q + 3'h1;
                if (settle_q == 3'h5) begin
                    firstDone_q <= 1'b1;
                    sampleNow_q <= 1'b1;
                end
            end else if (sampTmr_q >= SAMPLE_CYC - 36'h1) begin
                sampTmr_q   <= 36'h0;
                sampleNow_q <= 1'b1;
            end else begin
                sampTmr_q <= sampTmr_q + 36'h1;
            end
        end
    end

    // Trip comparators use the settled value, not the pins.
    // A reference write above the fixed limit is clamped,
    // and the clamp shows in status and the sense word.

    wire fixedTrip = tStable_q > `DHM_TEMP_LIMIT;
    wire refTrip   = tStable_q > refTemp_q;
    wire [7:0] wrTemp = (pwdata[31:8] != 24'h0 || pwdata[7:0] > `DHM_TEMP_LIMIT) ? `DHM_TEMP_LIMIT : pwdata[7:0];
    wire       wrRound = (pwdata[31:8] != 24'h0) || (pwdata[7:0] > `DHM_TEMP_LIMIT);
    wire       wrStatus = apbWr && (paddr == `DHM_ADDR_STATUS);

    // Sense codes share one register; the last one wins.
    // Order: rounding, predictive failure, then warning.
    // Event outputs are one-cycle pulses.
    // The method copy is registered so it leaves a flop.

    // Register writes, thermal sampling and sticky status; a set wins over a same-cycle clear.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            healthMonitorDisable_q  <= 1'b0;
            tempWarningEnable_q     <= 1'b0;
            exceptionReportMethod_q <= 4'h0;
            intervalLen_q           <= `DHM_RST_INTERVAL;
            errThresh_q             <= `DHM_RST_ERRTHR;
            predThresh_q            <= `DHM_RST_PREDTHR;
            refTemp_q               <= `DHM_TEMP_LIMIT;
            measTemp_q              <= 8'h00;
            status_q                <= 4'h0;
            predSticky_q            <= {NUM_ATTR{1'b0}};
            logParam_q              <= 16'h0000;
            attrSel_q               <= 3'h0;
            tempWarnEvent           <= 1'b0;
            predFailEvent           <= 1'b0;
            frameSaveReq            <= 1'b0;
            senseCode               <= 24'h0;
            senseFru                <= 8'h00;
            exceptionReportMethod   <= 4'h0;
        end else begin
            tempWarnEvent         <= 1'b0;
            predFailEvent         <= 1'b0;
            frameSaveReq          <= 1'b0;
            exceptionReportMethod <= exceptionReportMethod_q;
            if (apbWr) begin
                case (paddr)
                    `DHM_ADDR_CTRL: begin
                        healthMonitorDisable_q  <= pwdata[`DHM_CTRL_DISABLE];
                        tempWarningEnable_q     <= pwdata[`DHM_CTRL_WARN_EN];
                        exceptionReportMethod_q <= pwdata[`DHM_CTRL_EXCEPTION_REPORT_METHOD_HI:`DHM_CTRL_EXCEPTION_REPORT_METHOD_LO];
                    end
                    `DHM_ADDR_INTERVAL: intervalLen_q <= pwdata[CNT_W-1:0];
                    `DHM_ADDR_ERRTHR:   errThresh_q   <= pwdata[CNT_W-1:0];
                    `DHM_ADDR_PREDTHR:  predThresh_q  <= pwdata[HIST_W-1:0];
                    `DHM_ADDR_REFTEMP:  refTemp_q     <= wrTemp;
                    `DHM_ADDR_LOGPAGE: begin
                        logParam_q <= pwdata[15:0];
                        attrSel_q  <= pwdata[18:16];
                    end
                    default: ;
                endcase
            end
            // Write-one-to-clear first, then hardware sets override it.
            if (wrStatus) begin
                status_q     <= status_q & ~pwdata[3:0];
                predSticky_q <= predSticky_q & ~pwdata[`DHM_ST_PRED_LO+NUM_ATTR-1:`DHM_ST_PRED_LO];
            end
            if (apbWr && paddr == `DHM_ADDR_REFTEMP && wrRound) begin
                status_q[`DHM_ST_ROUNDED] <= 1'b1;
                senseCode                 <= `DHM_SENSE_ROUND;
            end
            if (!healthMonitorDisable_q && (predHit & ~predSticky_q) != {NUM_ATTR{1'b0}}) begin
                predSticky_q  <= predSticky_q | predHit;
                predFailEvent <= 1'b1;
                senseCode     <= `DHM_SENSE_PRED;
            end

            // A sample due while disabled is skipped, not deferred.
            if (sampleNow_q && !healthMonitorDisable_q) begin
                measTemp_q <= tStable_q;
                if (fixedTrip) begin
                    status_q[`DHM_ST_FIXED_TRIP] <= 1'b1;
                    status_q[`DHM_ST_FRAME_SAVE] <= 1'b1;
                    frameSaveReq                 <= 1'b1;
                end
                if (refTrip) begin
                    status_q[`DHM_ST_REF_TRIP] <= 1'b1;
                end
                // Warning only when enabled and a reporting method is selected.
                if ((fixedTrip || refTrip) && tempWarningEnable_q && exceptionReportMethod_q != 4'h0) begin
                    tempWarnEvent <= 1'b1;
                    senseCode     <= `DHM_SENSE_TEMP;
                    senseFru      <= tStable_q;
                end
            end
        end
    end

    // The history view follows the lane index last written
    // to the log page; an index past the last lane reads zero.
    // Trade-off: one wide mux instead of shadow registers.

    // Read mux; unmapped addresses read zero and report an error.
    reg  [31:0] rdData;
    reg         rdErr;
    reg  [HIST_W-1:0] histSel;
    integer i;
    always @* begin
        histSel = {HIST_W{1'b0}};
        for (i = 0; i < NUM_ATTR; i = i + 1) begin
            if (attrSel_q == i[2:0]) begin
                histSel = hist_q[i];
            end
        end
        rdErr  = 1'b0;
        rdData = 32'h0;
        case (paddr)
            `DHM_ADDR_CTRL:     rdData = {24'h0, exceptionReportMethod_q, 2'b00, tempWarningEnable_q,
                                          healthMonitorDisable_q};
            `DHM_ADDR_INTERVAL: rdData = {{(32-CNT_W){1'b0}}, intervalLen_q};
            `DHM_ADDR_ERRTHR:   rdData = {{(32-CNT_W){1'b0}}, errThresh_q};
            `DHM_ADDR_PREDTHR:  rdData = {{(32-HIST_W){1'b0}}, predThresh_q};
            `DHM_ADDR_REFTEMP:  rdData = {24'h0, refTemp_q};
            `DHM_ADDR_TEMP:     rdData = {24'h0, measTemp_q};
            `DHM_ADDR_STATUS:   rdData = {{(24-NUM_ATTR){1'b0}}, predSticky_q, 4'h0, status_q};
            `DHM_ADDR_HIST:     rdData = {{(32-HIST_W){1'b0}}, histSel};
            `DHM_ADDR_SENSE:    rdData = {senseFru, senseCode};
            // Temperature log page view selected by parameter code.
            `DHM_ADDR_LOGPAGE: begin
                if (logParam_q == `DHM_PARAM_PRIMARY) begin
                    rdData = {`DHM_LOG_PAGE, logParam_q[7:0], 8'h00, measTemp_q};
                end else if (logParam_q == `DHM_PARAM_REF) begin
                    rdData = {`DHM_LOG_PAGE, logParam_q[7:0], 8'h00, refTemp_q};
                end else begin
                    rdData = {`DHM_LOG_PAGE, logParam_q[7:0], 16'h0000};
                end
            end
            default: rdErr = 1'b1;
        endcase
    end

    // Bus walk: setup edge, first access edge raises pready,
    // the next edge takes the answer and lands a write.
    // pready toggles, so a held access is never answered two cycles running.

    // APB answer registers; pready rises for the second access cycle and holds one cycle.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apbAcc & ~pready;
            pslverr <= apbAcc & ~pready & rdErr;
            if (apbRd && !pready) begin
                prdata <= rdData;
            end
        end
    end

endmodule // dhm_monitor
`default_nettype wire

// [test/dhm_monitor_sva.sv]
// Checker that watches the health monitor ports.
`default_nettype none
`include "dhm_consts.vh"
module dhm_monitor_sva (
    // Clock and reset.
    input wire logic        ref_clk,
    input wire logic        rst,
    // Register bus.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Sensor and host events.
    input wire logic [7:0]  sensorTemp,
    input wire logic        predFailEvent,
    input wire logic        tempWarnEvent,
    input wire logic [23:0] senseCode,
    input wire logic [7:0]  senseFru,
    input wire logic [3:0]  exceptionReportMethod,
    input wire logic        frameSaveReq
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks share the one clock and its reset.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    property p_busAnswer; psel && penable && !pready |=> pready; endproperty
    a_busAnswer: assert property (p_busAnswer) else $error("bus answer not after one wait state");
    property p_errWithReady; pslverr |-> pready; endproperty
    a_errWithReady: assert property (p_errWithReady) else $error("error flag without ready");
    property p_refRound; psel && penable && pready && pwrite && paddr == `DHM_ADDR_REFTEMP && pwdata > 32'h44
        |-> ##[0:2] senseCode == `DHM_SENSE_ROUND; endproperty
    a_refRound: assert property (p_refRound) else $error("no rounding sense");
    property p_tempSense; tempWarnEvent |-> ##[0:1] senseCode == `DHM_SENSE_TEMP; endproperty
    a_tempSense: assert property (p_tempSense) else $error("wrong warning sense");
    property p_tempFru; tempWarnEvent && $past(sensorTemp, 8) == sensorTemp |-> ##[0:1] senseFru == sensorTemp;
    endproperty
    a_tempFru: assert property (p_tempFru) else $error("sense unit field not the temperature");
    property p_warnMethod; tempWarnEvent |-> exceptionReportMethod != 4'h0; endproperty
    a_warnMethod: assert property (p_warnMethod) else $error("warning with no report method");
    property p_frameHot; frameSaveReq && $past(sensorTemp, 8) == sensorTemp |-> sensorTemp > `DHM_TEMP_LIMIT;
    endproperty
    a_frameHot: assert property (p_frameHot) else $error("frame saved below fixed trip");
    property p_frameOnce; frameSaveReq |=> !frameSaveReq [*8]; endproperty
    a_frameOnce: assert property (p_frameOnce) else $error("frame request repeated");
    property p_predSense; predFailEvent |-> ##[0:1] senseCode == `DHM_SENSE_PRED; endproperty
    a_predSense: assert property (p_predSense) else $error("wrong predictive sense");
endmodule // dhm_monitor_sva
bind dhm_monitor dhm_monitor_sva dhm_monitor_sva_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .sensorTemp(sensorTemp),
    .predFailEvent(predFailEvent), .tempWarnEvent(tempWarnEvent), .senseCode(senseCode), .senseFru(senseFru),
    .exceptionReportMethod(exceptionReportMethod), .frameSaveReq(frameSaveReq));
`default_nettype wire

// [test/dhm_host_model.sv]
// Host model that reaches the monitor registers over the bus.
`default_nettype none
`include "dhm_consts.vh"
module dhm_host_model (
    // Clock.
    input  wire logic        ref_clk,
    // Register bus.
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idle from time zero so nothing is requested during reset.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // One transfer; address and data flip after release so stale values never look valid.
    task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        if (n >= 20) begin
            dhm_monitor_tb_top.hangCut();
        end
    endtask
    // Control word: monitor disable, warning enable and report method.
    task automatic setControl(input logic dis, input logic warnEn, input logic [3:0] method);
        logic [31:0] q;
        logic        e;
        access(1'b1, `DHM_ADDR_CTRL, {24'h0, method, 2'b00, warnEn, dis}, q, e);
    endtask
endmodule // dhm_host_model
`default_nettype wire

// [test/dhm_monitor_tb_top.sv]
// Self-checking bench for the drive health monitor.
`default_nettype none
`include "dhm_consts.vh"
module dhm_monitor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, predFailEvent, tempWarnEvent, frameSaveReq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  opStrobe, errStrobe, exceptionReportMethod;
    logic [7:0]  sensorTemp, senseFru;
    logic [23:0] senseCode;
    int          num_errors, check_count, predCount, warnCount, frameCount;
    // Short sample period keeps each thermal phase to a few hundred cycles.
    dhm_monitor #(.SAMPLE_CYC(36'd200)) dhm_monitor_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .opStrobe(opStrobe), .errStrobe(errStrobe), .sensorTemp(sensorTemp), .predFailEvent(predFailEvent),
        .tempWarnEvent(tempWarnEvent), .senseCode(senseCode), .senseFru(senseFru),
        .exceptionReportMethod(exceptionReportMethod), .frameSaveReq(frameSaveReq));
    dhm_host_model dhm_host_model_i (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Clock at 50 MHz.
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;
    // Event pulses are tallied so scenarios can judge them afterwards.
    always @(posedge ref_clk) begin
        predCount <= predCount + int'(predFailEvent === 1'b1);
        warnCount <= warnCount + int'(tempWarnEvent === 1'b1);
        frameCount <= frameCount + int'(frameSaveReq === 1'b1);
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic hangCut();
        num_errors++;
        $display("unexpected bus wait: expected ready, seen none");
        give_verdict();
    endtask
    task automatic waitClk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        dhm_host_model_i.access(1'b1, a, d, q, e);
    endtask
    task automatic expectReg(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        logic        e;
        dhm_host_model_i.access(1'b0, a, 32'h0, q, e);
        check(what, exp, q);
    endtask
    // One-cycle strobes with a gap, as the event inputs expect.
    task automatic pulse(input int a, input logic isErr, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            opStrobe[a] <= !isErr;
            errStrobe[a] <= isErr;
            @(posedge ref_clk);
            opStrobe <= 4'h0;
            errStrobe <= 4'h0;
        end
        waitClk(3);
    endtask
    task automatic expectHist(input int a, input logic [31:0] exp);
        wr(`DHM_ADDR_LOGPAGE, {13'h0, a[2:0], 16'h0});
        expectReg(`DHM_ADDR_HIST, exp, "history");
    endtask
    task automatic scenRegisters();
        logic [31:0] q;
        logic        e;
        expectReg(`DHM_ADDR_INTERVAL, {16'h0, `DHM_RST_INTERVAL}, "interval");
        expectReg(`DHM_ADDR_ERRTHR, {16'h0, `DHM_RST_ERRTHR}, "error threshold");
        expectReg(`DHM_ADDR_REFTEMP, 32'h44, "reference");
        dhm_host_model_i.access(1'b0, 12'h030, 32'h0, q, e);
        check("unmapped error", 32'h1, {31'h0, e});
        wr(`DHM_ADDR_REFTEMP, 32'h50);
        expectReg(`DHM_ADDR_REFTEMP, 32'h44, "rounded reference");
        check("rounding sense", {8'h0, `DHM_SENSE_ROUND}, {8'h0, senseCode});
        for (int c = 0; c < 2; c++) begin
            wr(`DHM_ADDR_LOGPAGE, c);
            expectReg(`DHM_ADDR_LOGPAGE, {`DHM_LOG_PAGE, 8'(c), 8'h00, (c == 0) ? 8'h19 : 8'h44}, "log page");
        end
    endtask
    task automatic scenErrorRate();
        wr(`DHM_ADDR_INTERVAL, 32'h4);
        wr(`DHM_ADDR_ERRTHR, 32'h2);
        wr(`DHM_ADDR_PREDTHR, 32'h2);
        pulse(0, 1'b1, 3);
        expectHist(0, 32'h1);
        pulse(1, 1'b1, 2);
        pulse(1, 1'b0, 4);
        expectHist(1, 32'h0);
        pulse(0, 1'b1, 3);
        check("predictive events", 32'h1, predCount);
        expectHist(0, 32'h2);
        pulse(0, 1'b0, 4);
        expectHist(0, 32'h1);
        dhm_host_model_i.setControl(1'b1, 1'b0, 4'h0);
        pulse(0, 1'b1, 3);
        expectHist(0, 32'h1);
        dhm_host_model_i.setControl(1'b0, 1'b1, 4'h4);
    endtask
    // One sample period after the sensor settles, with status cleared first.
    task automatic thermPhase(input logic [7:0] t, output int dw, output int df, output logic [31:0] st);
        logic e;
        @(posedge ref_clk);
        sensorTemp <= t;
        waitClk(8);
        dhm_host_model_i.access(1'b1, `DHM_ADDR_STATUS, 32'hffffffff, st, e);
        dw = warnCount;
        df = frameCount;
        waitClk(200);
        dw = warnCount - dw;
        df = frameCount - df;
        dhm_host_model_i.access(1'b0, `DHM_ADDR_STATUS, 32'h0, st, e);
    endtask
    task automatic scenThermal();
        int          dw, df;
        logic [31:0] st;
        wr(`DHM_ADDR_REFTEMP, 32'h44);
        thermPhase(8'h44, dw, df, st);
        check("quiet at limit", 32'h0, dw + df + st[3:0]);
        thermPhase(8'h45, dw, df, st);
        check("fixed trip", 32'h1, dw > 0 && df > 0 && st[1:0] == 2'b11);
        check("sense code", {8'h0, `DHM_SENSE_TEMP}, {8'h0, senseCode});
        check("sense unit", 32'h45, {24'h0, senseFru});
        wr(`DHM_ADDR_REFTEMP, 32'h30);
        thermPhase(8'h31, dw, df, st);
        check("user trip", 32'h2, {st[3:0], 28'h0} >> 28 | 32'(df));
        dhm_host_model_i.setControl(1'b0, 1'b0, 4'h4);
        thermPhase(8'h46, dw, df, st);
        check("warning off", 32'h0, dw);
    endtask
    initial begin
        rst = 1'b1;
        opStrobe = 4'h0;
        errStrobe = 4'h0;
        sensorTemp = 8'h19;
        waitClk(20);
        rst <= 1'b0;
        waitClk(12);
        scenRegisters();
        scenErrorRate();
        scenThermal();
        give_verdict();
    end
endmodule // dhm_monitor_tb_top
`default_nettype wire
